/* design/wsc_params.svh */
// constants for the wait-state controller
`ifndef WSC_PARAMS_SVH
`define WSC_PARAMS_SVH
`define WSC_REG_INDEX     16'hFFC2
`define WSC_REG_BYTE_ADDR ({`WSC_REG_INDEX, 2'b00})
`define WSC_RESET         8'hC8
`define WSC_FIXED_ONES    2'h3
`define WSC_FIXED_HI      7
`define WSC_FIXED_LO      6
`define WSC_HALVE_BIT     5
`define WSC_RSV_BIT       4
`define WSC_MODE_HI       3
`define WSC_MODE_LO       2
`define WSC_CNT_HI        1
`define WSC_CNT_LO        0
`define WSC_MODE_PROG     2'h0
`define WSC_MODE_NONE     2'h1
`define WSC_MODE_PIN      2'h2
`define WSC_MODE_AUTO     2'h3
`define WSC_CNT_ZERO      2'h0
`define WSC_CNT_ONE       2'h1
`define WSC_RESP_OKAY     2'h0
`define WSC_RESP_DECERR   2'h3
`define WSC_RDATA_PAD     24'h0
`endif

/* design/wsc_pkg.sv */
// types shared by the wait-state controller files
package wsc_pkg;
	typedef enum logic [2:0] {
		wsc_st_idle,
		wsc_st_t1,
		wsc_st_t2,
		wsc_st_tw,
		wsc_st_t3
	} wsc_state_t;
	typedef logic [7:0] wsc_byte_t;
	typedef logic [1:0] wsc_two_t;
endpackage

/* design/wsc_periph_clk.sv */
// clock enable for the supporting modules, full or half rate
`timescale 1ns/1ps
`include "wsc_params.svh"
module wsc_periph_clk import wsc_pkg::*; (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic halve,
	output logic      clk_en_r
);
	logic clk_en_nxt;

	always_comb begin
		clk_en_nxt = halve ? ~clk_en_r : 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_en_r <= 1'b1;
		end else begin
			clk_en_r <= clk_en_nxt;
		end
	end
endmodule // wsc_periph_clk

/* design/wsc_axil.sv */
// axi4-lite slave front end for the single control register
`timescale 1ns/1ps
`include "wsc_params.svh"
module wsc_axil import wsc_pkg::*; #(
	parameter int ADDR_W = 18
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic                   reg_wr,
	output wsc_byte_t              reg_wdata,
	input  wire wsc_byte_t         reg_rdata
);
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		addr_hit = (a == ADDR_W'(`WSC_REG_BYTE_ADDR));
	endfunction

	logic [ADDR_W-1:0] awaddr_r, awaddr_nxt, araddr_r, araddr_nxt;
	wsc_byte_t         wbyte_r, wbyte_nxt;
	logic              wlane_r, wlane_nxt, aw_full_r, aw_full_nxt;
	logic              w_full_r, w_full_nxt, awready_nxt, wready_nxt;
	logic              bvalid_nxt, arready_nxt, rvalid_nxt, fire;
	logic [1:0]        bresp_nxt, rresp_nxt;
	logic [31:0]       rdata_nxt;

	always_comb begin
		fire        = aw_full_r && w_full_r && !bvalid;
		awaddr_nxt  = (awvalid && awready) ? awaddr : awaddr_r;
		wbyte_nxt   = (wvalid && wready) ? wdata[7:0] : wbyte_r;
		wlane_nxt   = (wvalid && wready) ? wstrb[0] : wlane_r;
		aw_full_nxt = fire ? 1'b0 : (aw_full_r || (awvalid && awready));
		w_full_nxt  = fire ? 1'b0 : (w_full_r || (wvalid && wready));
		awready_nxt = !aw_full_nxt;
		wready_nxt  = !w_full_nxt;
		bvalid_nxt  = fire ? 1'b1 : (bvalid && !bready);
		bresp_nxt   = bresp;
		if (fire) begin
			bresp_nxt = addr_hit(awaddr_r) ? `WSC_RESP_OKAY
			                               : `WSC_RESP_DECERR;
		end
		reg_wr      = fire && addr_hit(awaddr_r) && wlane_r;
		reg_wdata   = wbyte_r;
		araddr_nxt  = (arvalid && arready) ? araddr : araddr_r;
		rvalid_nxt  = (rvalid && !rready) || (!rvalid && !arready);
		arready_nxt = !rvalid_nxt && !(arvalid && arready);
		rdata_nxt   = rdata;
		rresp_nxt   = rresp;
		if (!rvalid && !arready) begin
			rdata_nxt = addr_hit(araddr_r) ? {`WSC_RDATA_PAD, reg_rdata}
			                               : 32'h0;
			rresp_nxt = addr_hit(araddr_r) ? `WSC_RESP_OKAY
			                               : `WSC_RESP_DECERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_r  <= '0;
			araddr_r  <= '0;
			wbyte_r   <= '0;
			wlane_r   <= 1'b0;
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			awready   <= 1'b1;
			wready    <= 1'b1;
			bvalid    <= 1'b0;
			bresp     <= `WSC_RESP_OKAY;
			arready   <= 1'b1;
			rvalid    <= 1'b0;
			rdata     <= 32'h0;
			rresp     <= `WSC_RESP_OKAY;
		end else begin
			awaddr_r  <= awaddr_nxt;
			araddr_r  <= araddr_nxt;
			wbyte_r   <= wbyte_nxt;
			wlane_r   <= wlane_nxt;
			aw_full_r <= aw_full_nxt;
			w_full_r  <= w_full_nxt;
			awready   <= awready_nxt;
			wready    <= wready_nxt;
			bvalid    <= bvalid_nxt;
			bresp     <= bresp_nxt;
			arready   <= arready_nxt;
			rvalid    <= rvalid_nxt;
			rdata     <= rdata_nxt;
			rresp     <= rresp_nxt;
		end
	end
endmodule // wsc_axil

/* design/wsc_top.sv */
// wait-state controller: control register, bus cycle stretcher
// Behaviour
// - hardware reset and hardware standby load the register with C8 hex.
// - software standby leaves the register contents as they are.
// - bits 7 and 6 ignore writes and always read as one.
// - bit 4 is a spare bit, written and read back, zero at reset.
// - bits 3:2 pick programmed, none, pin (default) or pin auto-wait mode.
// - bits 1:0 give zero to three inserted wait states, zero at reset.
// - programmed mode inserts exactly the count on external accesses.
// - pin mode adds a wait if the pin is low in the last wait.
// - pin mode keeps adding waits while the wait pin stays low.
// - auto-wait samples the pin in T2, inserts the count only if low.
// - auto-wait never stretches past the count, whatever the pin does.
// - the wait pin is heeded only on external address accesses.
// - bit 5 is the read/write peripheral clock halving control.
// - halving bit zero gives full rate, one gives half rate.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "wsc_params.svh"
module wsc_top import wsc_pkg::*; #(
	parameter int ADDR_W     = 18,
	parameter int BUS_ADDR_W = 16
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [ADDR_W-1:0]     awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	input  wire logic [ADDR_W-1:0]     araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	input  wire logic                  hw_standby,
	input  wire logic                  acc_start,
	input  wire logic                  acc_ext,
	input  wire logic [BUS_ADDR_W-1:0] acc_addr,
	input  wire logic                  wait_req_n,
	output logic                       bus_ready_r,
	output logic                       bus_done_r,
	output logic                       ext_strobe_r,
	output logic [BUS_ADDR_W-1:0]      ext_addr_r,
	output logic                       wait_active_r,
	output logic                       periph_clk_en
);
	////////////////////////////////////////////////////////////////////
	// register bus
	wsc_byte_t wait_state_control_r, wait_state_control_nxt;
	wsc_byte_t reg_wdata;
	logic      reg_wr;

	wsc_axil #(
		.ADDR_W (ADDR_W)
	) u_axil (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.awaddr    (awaddr),
		.awvalid   (awvalid),
		.awready   (awready),
		.wdata     (wdata),
		.wstrb     (wstrb),
		.wvalid    (wvalid),
		.wready    (wready),
		.bresp     (bresp),
		.bvalid    (bvalid),
		.bready    (bready),
		.araddr    (araddr),
		.arvalid   (arvalid),
		.arready   (arready),
		.rdata     (rdata),
		.rresp     (rresp),
		.rvalid    (rvalid),
		.rready    (rready),
		.reg_wr    (reg_wr),
		.reg_wdata (reg_wdata),
		.reg_rdata (wait_state_control_r)
	);

	////////////////////////////////////////////////////////////////////
	// wait-state control register
	logic     peripheral_clock_halve;
	wsc_two_t wait_mode_sel;
	wsc_two_t wait_count_sel;

	assign peripheral_clock_halve = wait_state_control_r[`WSC_HALVE_BIT];
	assign wait_mode_sel  = wait_state_control_r[`WSC_MODE_HI:`WSC_MODE_LO];
	assign wait_count_sel = wait_state_control_r[`WSC_CNT_HI:`WSC_CNT_LO];

	always_comb begin
		wait_state_control_nxt = wait_state_control_r;
		if (hw_standby) begin
			wait_state_control_nxt = `WSC_RESET;
		end else if (reg_wr) begin
			wait_state_control_nxt = {`WSC_FIXED_ONES,
			                          reg_wdata[`WSC_HALVE_BIT:0]};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wait_state_control_r <= `WSC_RESET;
		end else begin
			wait_state_control_r <= wait_state_control_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// supporting module clock
	wsc_periph_clk u_periph_clk (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.halve    (peripheral_clock_halve),
		.clk_en_r (periph_clk_en)
	);

	////////////////////////////////////////////////////////////////////
	// bus cycle sequencer
	wsc_state_t            state_r, state_nxt;
	wsc_two_t              cnt_r, cnt_nxt, mode_r, mode_nxt, wc_r, wc_nxt;
	logic                  ext_r, ext_nxt;
	logic [BUS_ADDR_W-1:0] addr_nxt;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		mode_nxt  = mode_r;
		wc_nxt    = wc_r;
		ext_nxt   = ext_r;
		addr_nxt  = ext_addr_r;
		unique case (state_r)
			wsc_st_idle: begin
				if (acc_start) begin
					state_nxt = wsc_st_t1;
					ext_nxt   = acc_ext;
					addr_nxt  = acc_addr;
					mode_nxt  = wait_mode_sel;
					wc_nxt    = wait_count_sel;
				end
			end
			wsc_st_t1: begin
				state_nxt = wsc_st_t2;
			end
			wsc_st_t2: begin
				state_nxt = wsc_st_t3;
				if (ext_r) begin
					unique case (mode_r)
						`WSC_MODE_PROG: begin
							if (wc_r != `WSC_CNT_ZERO) begin
								state_nxt = wsc_st_tw;
								cnt_nxt   = wc_r;
							end
						end
						`WSC_MODE_NONE: begin
							state_nxt = wsc_st_t3;
						end
						`WSC_MODE_PIN: begin
							if (wc_r != `WSC_CNT_ZERO) begin
								state_nxt = wsc_st_tw;
								cnt_nxt   = wc_r;
							end else if (!wait_req_n) begin
								state_nxt = wsc_st_tw;
								cnt_nxt   = `WSC_CNT_ONE;
							end
						end
						`WSC_MODE_AUTO: begin
							if (!wait_req_n && wc_r != `WSC_CNT_ZERO) begin
								state_nxt = wsc_st_tw;
								cnt_nxt   = wc_r;
							end
						end
					endcase
				end
			end
			wsc_st_tw: begin
				if (cnt_r != `WSC_CNT_ONE) begin
					cnt_nxt = cnt_r - `WSC_CNT_ONE;
				end else if (mode_r == `WSC_MODE_PIN && !wait_req_n) begin
					state_nxt = wsc_st_tw;
				end else begin
					state_nxt = wsc_st_t3;
				end
			end
			wsc_st_t3: begin
				state_nxt = wsc_st_idle;
			end
			default: begin
				state_nxt = wsc_st_idle;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r       <= wsc_st_idle;
			cnt_r         <= `WSC_CNT_ZERO;
			mode_r        <= `WSC_MODE_PIN;
			wc_r          <= `WSC_CNT_ZERO;
			ext_r         <= 1'b0;
			ext_addr_r    <= '0;
			bus_ready_r   <= 1'b1;
			bus_done_r    <= 1'b0;
			ext_strobe_r  <= 1'b0;
			wait_active_r <= 1'b0;
		end else begin
			state_r       <= state_nxt;
			cnt_r         <= cnt_nxt;
			mode_r        <= mode_nxt;
			wc_r          <= wc_nxt;
			ext_r         <= ext_nxt;
			ext_addr_r    <= addr_nxt;
			bus_ready_r   <= (state_nxt == wsc_st_idle);
			bus_done_r    <= (state_nxt == wsc_st_t3);
			ext_strobe_r  <= (state_nxt != wsc_st_idle) && ext_nxt;
			wait_active_r <= (state_nxt == wsc_st_tw);
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	logic [7:0] waits_seen_r;

	always_ff @(posedge aclk) begin
		if (!aresetn || state_r == wsc_st_t1) begin
			waits_seen_r <= 8'h0;
		end else if (state_r == wsc_st_tw && waits_seen_r != 8'hFF) begin
			waits_seen_r <= waits_seen_r + 8'h1;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	standby_load_a: assert property (
		hw_standby |=> wait_state_control_r == `WSC_RESET)
		else $error("standby did not reload the control register");

	fixed_ones_a: assert property (
		reg_wr |=> wait_state_control_r[`WSC_FIXED_HI:`WSC_FIXED_LO]
		           == `WSC_FIXED_ONES)
		else $error("top control bits not held at one");

	write_back_a: assert property (
		reg_wr && !hw_standby |=> wait_state_control_r[`WSC_HALVE_BIT:0]
		    == $past(reg_wdata[`WSC_HALVE_BIT:0]))
		else $error("writable control bits not stored");

	prog_exact_a: assert property (
		state_r == wsc_st_t3 && ext_r && mode_r == `WSC_MODE_PROG
		|-> waits_seen_r == 8'(wc_r))
		else $error("programmed wait count not inserted exactly");

	pin_extend_a: assert property (
		state_r == wsc_st_tw && cnt_r == `WSC_CNT_ONE
		&& mode_r == `WSC_MODE_PIN && !wait_req_n
		|=> state_r == wsc_st_tw && wait_active_r)
		else $error("low wait pin did not extend the access");

	auto_sample_a: assert property (
		state_r == wsc_st_t2 && ext_r && mode_r == `WSC_MODE_AUTO
		&& wait_req_n |=> state_r == wsc_st_t3 ##1 state_r == wsc_st_idle)
		else $error("auto-wait inserted waits with pin high");

	auto_bound_a: assert property (
		state_r == wsc_st_t3 && mode_r == `WSC_MODE_AUTO
		|-> waits_seen_r <= 8'(wc_r))
		else $error("auto-wait stretched past the count");

	internal_none_a: assert property (
		state_r == wsc_st_t3 && !ext_r |-> waits_seen_r == 8'h0)
		else $error("internal access received wait states");

	hold_strobe_a: assert property (
		state_r == wsc_st_tw |=> $stable(ext_addr_r) && ext_strobe_r)
		else $error("address or strobe moved during a wait");

	clk_rate_a: assert property (
		(!peripheral_clock_halve && !$past(peripheral_clock_halve)
		 |-> periph_clk_en)
		and (peripheral_clock_halve
		 |=> periph_clk_en != $past(periph_clk_en)))
		else $error("peripheral clock rate wrong");

	prog_three_c: cover property (
		state_r == wsc_st_t3 && mode_r == `WSC_MODE_PROG
		&& waits_seen_r == 8'h3);
	pin_extra_c: cover property (
		state_r == wsc_st_t3 && mode_r == `WSC_MODE_PIN
		&& waits_seen_r > 8'(wc_r));
	auto_wait_c: cover property (
		state_r == wsc_st_t3 && mode_r == `WSC_MODE_AUTO
		&& waits_seen_r != 8'h0);
	internal_c: cover property (state_r == wsc_st_t3 && !ext_r);
endmodule // wsc_top

/* test/wsc_ext_dev.sv */
// slow external device answering with the active-low wait request
`timescale 1ns/1ps
module wsc_ext_dev (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       ext_strobe_r,
	input  wire logic [7:0] hold,
	input  wire logic       low,
	output logic            wait_req_n
);
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	////////////////////////////////////////////////////////////////////////
	// cycles since the strobe went active, saturating
	always_comb begin
		cnt_nxt = 8'h00;
		if (ext_strobe_r && cnt_r != 8'hFF) begin
			cnt_nxt = cnt_r + 8'h01;
		end else if (ext_strobe_r) begin
			cnt_nxt = cnt_r;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// low for hold cycles of an access, then released to the pull-up
	assign wait_req_n = !(low || (ext_strobe_r && cnt_r < hold));
endmodule // wsc_ext_dev

/* test/external_bus_wait_state_controller_bench.sv */
// self-checking bench for the wait-state controller
`timescale 1ns/1ps
`include "wsc_params.svh"
module external_bus_wait_state_controller_bench;
	localparam logic [17:0] REG_A = `WSC_REG_BYTE_ADDR;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [17:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        hw_standby, acc_start, acc_ext, wait_req_n;
	logic [15:0] acc_addr, ext_addr_r;
	logic        bus_ready_r, bus_done_r, ext_strobe_r, wait_active_r;
	logic        periph_clk_en, dev_low;
	logic [7:0]  dev_hold;
	int          num_errors, cmp_count;
	wsc_top u_wsc_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .hw_standby(hw_standby), .acc_start(acc_start),
		.acc_ext(acc_ext), .acc_addr(acc_addr), .wait_req_n(wait_req_n),
		.bus_ready_r(bus_ready_r), .bus_done_r(bus_done_r),
		.ext_strobe_r(ext_strobe_r), .ext_addr_r(ext_addr_r),
		.wait_active_r(wait_active_r), .periph_clk_en(periph_clk_en));
	wsc_ext_dev u_wsc_ext_dev (.aclk(aclk), .aresetn(aresetn),
		.ext_strobe_r(ext_strobe_r), .hold(dev_hold), .low(dev_low),
		.wait_req_n(wait_req_n));
	////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic hang;
		num_errors++;
		$display("CHECK FAILED t=%0t wait bound used up", $time);
		final_report();
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic axi_wr(input logic [17:0] a, input logic [7:0] d,
		output logic [1:0] r);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == 50) hang();
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [17:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == 50) hang();
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic set_reg(input logic [7:0] v);
		logic [1:0] r;
		axi_wr(REG_A, v, r);
		check(r, `WSC_RESP_OKAY);
	endtask
	task automatic read_is(input logic [17:0] a, input logic [7:0] v,
		input logic [1:0] re);
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(a, d, r);
		check(d, {24'h000000, v});
		check(r, re);
	endtask
	// one bus access; counts the wait cycles until the done pulse
	task automatic acc(input logic ext, input logic [7:0] hold,
		input logic low, output int waits);
		int n;
		logic [15:0] a;
		a = ext ? 16'hA5C3 : 16'hFB80;
		@(posedge aclk);
		acc_start <= 1'b1;
		acc_ext <= ext;
		acc_addr <= a;
		dev_hold <= hold;
		dev_low <= low;
		@(posedge aclk);
		acc_start <= 1'b0;
		waits = 0;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			#1;
			if (wait_active_r === 1'b1) waits++;
			check(ext_strobe_r, ext);
			check(bus_ready_r, 1'b0);
			if (ext) check(ext_addr_r, a);
			if (bus_done_r === 1'b1) break;
		end
		if (n == 100) hang();
		dev_low <= 1'b0;
		@(posedge aclk);
		#1;
		check(bus_done_r, 1'b0);
		check(ext_strobe_r, 1'b0);
		check(bus_ready_r, 1'b1);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		read_is(REG_A, `WSC_RESET, `WSC_RESP_OKAY);
		repeat (3) begin
			@(posedge aclk);
			#1;
			check(periph_clk_en, 1'b1);
		end
		$display("test reset values done");
	endtask
	task automatic t_fields;
		logic [1:0] r;
		set_reg(8'h00);
		read_is(REG_A, 8'hC0, `WSC_RESP_OKAY);
		set_reg(8'hFF);
		read_is(REG_A, 8'hFF, `WSC_RESP_OKAY);
		set_reg(8'h10);
		read_is(REG_A, 8'hD0, `WSC_RESP_OKAY);
		axi_wr(18'h00100, 8'h2F, r);
		check(r, `WSC_RESP_DECERR);
		read_is(18'h00100, 8'h00, `WSC_RESP_DECERR);
		read_is(REG_A, 8'hD0, `WSC_RESP_OKAY);
		$display("test register fields done");
	endtask
	task automatic t_halve;
		logic p;
		set_reg(8'h20);
		@(posedge aclk);
		#1;
		p = periph_clk_en;
		repeat (4) begin
			@(posedge aclk);
			#1;
			check(periph_clk_en, !p);
			p = periph_clk_en;
		end
		$display("test clock halving done");
	endtask
	task automatic t_standby;
		set_reg(8'h3F);
		repeat (10) @(posedge aclk);
		read_is(REG_A, 8'hFF, `WSC_RESP_OKAY);
		hw_standby <= 1'b1;
		repeat (2) @(posedge aclk);
		hw_standby <= 1'b0;
		read_is(REG_A, `WSC_RESET, `WSC_RESP_OKAY);
		$display("test hardware standby done");
	endtask
	task automatic t_modes;
		int w;
		for (int c = 0; c < 4; c++) begin
			set_reg(8'(c));
			acc(1'b1, 8'hFF, 1'b0, w);
			check(w, c);
			acc(1'b1, 8'h00, 1'b0, w);
			check(w, c);
		end
		acc(1'b0, 8'h00, 1'b1, w);
		check(w, 0);
		set_reg(8'h07);
		acc(1'b1, 8'hFF, 1'b0, w);
		check(w, 0);
		set_reg(8'h0A);
		acc(1'b1, 8'h00, 1'b0, w);
		check(w, 2);
		acc(1'b1, 8'h04, 1'b0, w);
		check(w, 3);
		acc(1'b1, 8'h09, 1'b0, w);
		check(w, 8);
		acc(1'b0, 8'h00, 1'b1, w);
		check(w, 0);
		set_reg(8'h0E);
		acc(1'b1, 8'h00, 1'b0, w);
		check(w, 0);
		acc(1'b1, 8'hFF, 1'b0, w);
		check(w, 2);
		set_reg(8'h0F);
		acc(1'b1, 8'h03, 1'b0, w);
		check(w, 3);
		$display("test wait modes done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{hw_standby, acc_start, acc_ext, dev_low} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = '0;
		acc_addr = '0;
		dev_hold = '0;
		num_errors = 0;
		cmp_count = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_fields();
		t_halve();
		t_standby();
		t_modes();
		final_report();
	end
endmodule // external_bus_wait_state_controller_bench
